// ### rtl/timer_io_control_decode.sv
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer_io_control_decode
   import timer_io_pkg::*;
(
   input  wire logic                core_clk,          // Timer clock, 10 MHz
   input  wire logic                nrst,              // Async reset, low
   input  wire logic                clk_en,            // Freezes state
   // Classic Wishbone slave
   input  wire logic                wb_cyc_i,          // Bus cycle
   input  wire logic                wb_stb_i,          // Strobe
   input  wire logic                wb_we_i,           // Write enable
   input  wire logic [WB_ADR_W-1:0] wb_adr_i,          // Byte address
   input  wire logic [3:0]          wb_sel_i,          // Byte lanes
   input  wire logic [WB_DAT_W-1:0] wb_dat_i,          // Write data
   output logic      [WB_DAT_W-1:0] wb_dat_o,          // Read data
   output logic                     wb_ack_o,          // Acknowledge
   // Surrounding timer
   input  wire logic [NUM_CH-1:0]   counter_start_bit, // Counter running
   input  wire logic [NUM_CH-1:0]   pwm2_mode,         // Second PWM mode
   input  wire logic [NUM_CH-1:0]   counter_clear,     // Clear pulse
   input  wire logic                buffer_a_select,   // C buffers A
   input  wire logic                buffer_b_select,   // D buffers B
   input  wire logic [NUM_GR-1:0]   compare_match,     // Match pulses
   output logic      [NUM_GR-1:0]   capture_strobe,    // Capture pulses
   output logic      [NUM_GR-1:0]   compare_enabled,   // Compare role on
   // Timer pins
   input  wire logic [NUM_PIN-1:0]  pin_in,            // Pin levels
   output logic      [NUM_PIN-1:0]  pin_out,           // Driven levels
   output logic      [NUM_PIN-1:0]  pin_oe_n           // Low while driving
);

   // Register state of the block, apart from the flip-flops of the pin units
   typedef struct packed {
      logic [REG_W-1:0]    ch0_pin_ctrl_high;
      logic [REG_W-1:0]    ch0_pin_ctrl_low;
      logic [REG_W-1:0]    ch1_pin_ctrl;
      logic [REG_W-1:0]    ch2_pin_ctrl;
      logic [NUM_GR-1:0]   capture_flags;
      logic [NUM_GR-1:0]   match_flags;
      logic                ack;
      logic [WB_DAT_W-1:0] rdata;
   } state_s;

   state_s q;
   state_s d;

   field_t            field     [NUM_GR];
   field_t            alt_field [NUM_PIN];
   logic [NUM_GR-1:0] cap_evt;
   logic [NUM_GR-1:0] match_evt;
   logic [NUM_PIN-1:0] pin_level;
   logic [NUM_PIN-1:0] own_cap;
   logic [NUM_PIN-1:0] alt_cap;
   logic              access;
   logic              wr_lane0;
   logic              wr_hit;
   logic [WB_DAT_W-1:0] rd_word;

   // Field split of the control registers
   always_comb begin
      field[GR_A0] = q.ch0_pin_ctrl_high[FIELD_LO_POS +: FIELD_W];
      field[GR_B0] = q.ch0_pin_ctrl_high[FIELD_HI_POS +: FIELD_W];
      field[GR_A1] = q.ch1_pin_ctrl[FIELD_LO_POS +: FIELD_W];
      field[GR_B1] = q.ch1_pin_ctrl[FIELD_HI_POS +: FIELD_W];
      field[GR_A2] = q.ch2_pin_ctrl[FIELD_LO_POS +: FIELD_W];
      field[GR_B2] = q.ch2_pin_ctrl[FIELD_HI_POS +: FIELD_W];
      field[GR_C0] = q.ch0_pin_ctrl_low[FIELD_LO_POS +: FIELD_W];
      field[GR_D0] = q.ch0_pin_ctrl_low[FIELD_HI_POS +: FIELD_W];
      // A buffering C or D register loses its role
      if (buffer_a_select) begin
         field[GR_C0] = '0;
      end
      if (buffer_b_select) begin
         field[GR_D0] = '0;
      end
   end

   // Register C shares the first pin of channel 0
   always_comb begin
      for (int p = 0; p < NUM_PIN; p++) begin
         alt_field[p] = '0;
      end
      alt_field[0] = field[GR_C0];
   end

   // One pin unit per timer pin
   for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin
      localparam int unsigned GR = PIN_GR[p];
      localparam int unsigned CH = PIN_CH[p];
      timer_pin_unit u_pin (
         .core_clk    (core_clk),
         .nrst        (nrst),
         .clk_en      (clk_en),
         .field       (field[GR]),
         .match       (compare_match[GR]),
         .alt_field   (alt_field[p]),
         .alt_match   ((p == 0) ? compare_match[GR_C0] : 1'b0),
         .running     (counter_start_bit[CH]),
         .pwm2        (pwm2_mode[CH]),
         .cnt_clear   (counter_clear[CH]),
         .pin_in      (pin_in[p]),
         .pin_out     (pin_out[p]),
         .pin_oe_n    (pin_oe_n[p]),
         .pin_level   (pin_level[p]),
         .capture     (own_cap[p]),
         .alt_capture (alt_cap[p])
      );
   end

   // Capture strobes gathered per general register
   always_comb begin
      cap_evt = '0;
      for (int p = 0; p < NUM_PIN; p++) begin
         cap_evt[PIN_GR[p]] = own_cap[p];
      end
      cap_evt[GR_C0] = alt_cap[0];
   end

   // Compare matches that the fields act on
   always_comb begin
      for (int g = 0; g < NUM_GR; g++) begin
         compare_enabled[g] = out_enabled(field[g]);
         match_evt[g]       = compare_match[g] & compare_enabled[g];
      end
   end

   assign capture_strobe = cap_evt;

   // Bus access decode; a write lands at the edge where ack is seen
   assign access   = wb_cyc_i & wb_stb_i & ~q.ack;
   assign wr_hit   = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
   assign wr_lane0 = wr_hit & wb_sel_i[0];

   // Read multiplexer; unmapped addresses read as zero
   always_comb begin
      rd_word = '0;
      unique case (wb_adr_i)
         OFS_CH0_HIGH: rd_word[REG_W-1:0] = q.ch0_pin_ctrl_high;
         OFS_CH0_LOW:  rd_word[REG_W-1:0] = q.ch0_pin_ctrl_low;
         OFS_CH1:      rd_word[REG_W-1:0] = q.ch1_pin_ctrl;
         OFS_CH2:      rd_word[REG_W-1:0] = q.ch2_pin_ctrl;
         OFS_PIN_STATUS: begin
            rd_word[NUM_PIN-1:0]                   = pin_level;
            rd_word[STAT_OUT_POS +: NUM_PIN]       = pin_out;
            rd_word[STAT_OE_POS +: NUM_PIN]        = pin_oe_n;
         end
         OFS_EVENT_FLAGS: begin
            rd_word[NUM_GR-1:0]                    = q.capture_flags;
            rd_word[FLAG_MATCH_POS +: NUM_GR]      = q.match_flags;
         end
         default: rd_word = '0;
      endcase
   end

   // Next state of registers, flags and bus answer
   always_comb begin
      d       = q;
      d.ack   = access;
      d.rdata = access ? rd_word : q.rdata;
      if (wr_lane0) begin
         unique case (wb_adr_i)
            OFS_CH0_HIGH: d.ch0_pin_ctrl_high = wb_dat_i[REG_W-1:0];
            OFS_CH0_LOW:  d.ch0_pin_ctrl_low  = wb_dat_i[REG_W-1:0];
            OFS_CH1:      d.ch1_pin_ctrl      = wb_dat_i[REG_W-1:0];
            OFS_CH2:      d.ch2_pin_ctrl      = wb_dat_i[REG_W-1:0];
            default: ;
         endcase
      end
      // Write one to clear, a new event wins over the clear
      if (wr_hit && (wb_adr_i == OFS_EVENT_FLAGS)) begin
         if (wb_sel_i[0]) begin
            d.capture_flags = q.capture_flags & ~wb_dat_i[NUM_GR-1:0];
         end
         if (wb_sel_i[1]) begin
            d.match_flags =
               q.match_flags & ~wb_dat_i[FLAG_MATCH_POS +: NUM_GR];
         end
      end
      d.capture_flags = d.capture_flags | cap_evt;
      d.match_flags   = d.match_flags | match_evt;
   end

   // State register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q.ch0_pin_ctrl_high <= PIN_CTRL_RESET;
         q.ch0_pin_ctrl_low  <= PIN_CTRL_RESET;
         q.ch1_pin_ctrl      <= PIN_CTRL_RESET;
         q.ch2_pin_ctrl      <= PIN_CTRL_RESET;
         q.capture_flags     <= FLAGS_RESET;
         q.match_flags       <= FLAGS_RESET;
         q.ack               <= 1'b0;
         q.rdata             <= '0;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // Bus outputs straight from flip-flops
   assign wb_dat_o = q.rdata;
   assign wb_ack_o = q.ack;

endmodule : timer_io_control_decode
`default_nettype wire

// ### rtl/timer_io_pkg.sv
package timer_io_pkg;

   // Block geometry
   localparam int unsigned NUM_GR    = 8;   // General registers handled
   localparam int unsigned NUM_PIN   = 7;   // Timer pins handled
   localparam int unsigned NUM_CH    = 3;   // Timer channels
   localparam int unsigned FIELD_W   = 4;   // Width of one pin control field
   localparam int unsigned REG_W     = 8;   // Width of one pin control register
   localparam int unsigned WB_ADR_W  = 8;   // Byte address width on the bus
   localparam int unsigned WB_DAT_W  = 32;  // Bus data width

   // Register byte offsets
   localparam logic [7:0] OFS_CH0_HIGH    = 8'h00;
   localparam logic [7:0] OFS_CH0_LOW     = 8'h04;
   localparam logic [7:0] OFS_CH1         = 8'h08;
   localparam logic [7:0] OFS_CH2         = 8'h0c;
   localparam logic [7:0] OFS_PIN_STATUS  = 8'h10;
   localparam logic [7:0] OFS_EVENT_FLAGS = 8'h14;

   // Field positions inside a pin control register
   localparam int unsigned FIELD_LO_POS = 0;  // Register A or C
   localparam int unsigned FIELD_HI_POS = 4;  // Register B or D

   // Field positions inside the status words
   localparam int unsigned STAT_OUT_POS   = 8;   // Driven levels
   localparam int unsigned STAT_OE_POS    = 16;  // Output enables, active low
   localparam int unsigned FLAG_MATCH_POS = 8;   // Compare match flags

   // Values after reset
   localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET    = 8'h00;

   // General register indices
   localparam int unsigned GR_A0 = 0;
   localparam int unsigned GR_B0 = 1;
   localparam int unsigned GR_C0 = 2;
   localparam int unsigned GR_D0 = 3;
   localparam int unsigned GR_A1 = 4;
   localparam int unsigned GR_B1 = 5;
   localparam int unsigned GR_A2 = 6;
   localparam int unsigned GR_B2 = 7;

   // Owning general register and channel of each pin
   localparam int unsigned PIN_GR [NUM_PIN] = '{0, 1, 3, 4, 5, 6, 7};
   localparam int unsigned PIN_CH [NUM_PIN] = '{0, 0, 0, 1, 1, 2, 2};

   typedef logic [FIELD_W-1:0] field_t;

   // Field codes that drive a pin from compare matches
   function automatic logic out_enabled(input field_t f);
      return (f[3] == 1'b0) && (f[1:0] != 2'b00);
   endfunction : out_enabled

   // Field codes that capture: 1000, 1001, 101x
   function automatic logic capture_hit(input field_t f,
                                        input logic rise,
                                        input logic fall);
      if (f[3:2] != 2'b10) begin
         return 1'b0;
      end
      if (f[1]) begin
         return rise | fall;
      end
      return f[0] ? fall : rise;
   endfunction : capture_hit

   // Pin level after a compare match
   function automatic logic match_level(input field_t f, input logic cur);
      unique case (f[1:0])
         2'b01:   return 1'b0;
         2'b10:   return 1'b1;
         2'b11:   return ~cur;
         default: return cur;
      endcase
   endfunction : match_level

endpackage : timer_io_pkg

// ### rtl/timer_pin_unit.sv
`timescale 1ns/1ps
`default_nettype none
module timer_pin_unit
   import timer_io_pkg::*;
(
   input  wire logic   core_clk,    // Timer clock
   input  wire logic   nrst,        // Async reset, active low
   input  wire logic   clk_en,      // Freezes all state while low
   input  wire field_t field,       // Field of the owning register
   input  wire logic   match,       // Compare match of the owning register
   input  wire field_t alt_field,   // Field of a register sharing the pin
   input  wire logic   alt_match,   // Compare match of the sharing register
   input  wire logic   running,     // Channel counter start bit
   input  wire logic   pwm2,        // Channel in second pulse-width mode
   input  wire logic   cnt_clear,   // Counter cleared to zero, pulse
   input  wire logic   pin_in,      // Pin level, asynchronous
   output logic        pin_out,     // Driven pin level
   output logic        pin_oe_n,    // Output enable, low while driving
   output logic        pin_level,   // Synchronised pin level
   output logic        capture,     // Capture strobe of owning register
   output logic        alt_capture  // Capture strobe of sharing register
);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic out_lvl;
      logic oe_n;
      logic cap;
      logic alt_cap;
   } unit_s;

   unit_s q;
   unit_s d;
   logic  rise;
   logic  fall;
   logic  own_en;
   logic  alt_en;
   logic  init_lvl;

   // Edge detection on the second synchroniser stage only
   assign rise     = q.sync2 & ~q.prev;
   assign fall     = ~q.sync2 & q.prev;
   assign own_en   = out_enabled(field);
   assign alt_en   = out_enabled(alt_field);
   assign init_lvl = own_en ? field[2] : alt_field[2];

   // Next state of the pin
   always_comb begin
      d       = q;
      d.sync1 = pin_in;
      d.sync2 = q.sync1;
      d.prev  = q.sync2;
      d.oe_n  = ~(own_en | alt_en);
      if (!running) begin
         d.out_lvl = init_lvl;
      end else if (pwm2 && cnt_clear) begin
         d.out_lvl = init_lvl;
      end else if (match && own_en) begin
         d.out_lvl = match_level(field, q.out_lvl);
      end else if (alt_match && alt_en) begin
         d.out_lvl = match_level(alt_field, q.out_lvl);
      end
      d.cap     = capture_hit(field, rise, fall);
      d.alt_cap = capture_hit(alt_field, rise, fall);
   end

   // State register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '{oe_n: 1'b1, default: 1'b0};
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign pin_out     = q.out_lvl;
   assign pin_oe_n    = q.oe_n;
   assign pin_level   = q.sync2;
   assign capture     = q.cap;
   assign alt_capture = q.alt_cap;

endmodule : timer_pin_unit
`default_nettype wire

// ### dv/timer_io_chk.sv
`timescale 1ns/1ps
`default_nettype none
module timer_io_chk
   import timer_io_pkg::*;
(
   input wire logic               core_clk,          // Clock
   input wire logic               nrst,              // Reset, low
   input wire logic               clk_en,            // Clock enable
   input wire logic               wb_cyc_i,          // Bus cycle
   input wire logic               wb_stb_i,          // Strobe
   input wire logic               wb_ack_o,          // Acknowledge
   input wire logic [NUM_CH-1:0]  counter_start_bit, // Counters run
   input wire logic [NUM_CH-1:0]  pwm2_mode,         // Second PWM mode
   input wire logic [NUM_CH-1:0]  counter_clear,     // Clear pulses
   input wire logic               buffer_b_select,   // D buffers B
   input wire logic [NUM_GR-1:0]  compare_match,     // Match pulses
   input wire logic [NUM_GR-1:0]  capture_strobe,    // Capture pulses
   input wire logic [NUM_GR-1:0]  compare_enabled,   // Compare roles
   input wire logic [NUM_PIN-1:0] pin_in,            // Pin levels
   input wire logic [NUM_PIN-1:0] pin_out,           // Driven levels
   input wire logic [NUM_PIN-1:0] pin_oe_n           // Low while driving
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // Cycles since pin 1 last changed, saturating
   logic [3:0] age_q;
   logic       pin_q;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         age_q <= 4'hf;
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin_in[1];
         age_q <= (pin_in[1] != pin_q) ? 4'h0 :
                  (age_q == 4'hf) ? age_q : age_q + 4'h1;
      end
   end

   // A request the slave must take
   sequence bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
   endsequence

   a_ack_resp: assert property (bus_req |=> wb_ack_o)
      else $error("no ack one cycle after a request");
   a_ack_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
      else $error("ack held beyond one cycle");
   a_oe_follow: assert property ($past(clk_en) |->
      pin_oe_n[3] == !$past(compare_enabled[GR_A1]))
      else $error("output enable does not follow the field");
   a_hold_level: assert property ($past(clk_en) &&
      $past(counter_start_bit[1]) && !$past(compare_match[GR_A1]) &&
      !($past(pwm2_mode[1]) && $past(counter_clear[1]))
      |-> $stable(pin_out[3]))
      else $error("pin level moved without a match");
   a_cap_role: assert property (capture_strobe[GR_B0] |->
      !$past(compare_enabled[GR_B0]))
      else $error("capture while in compare role");
   a_cap_age: assert property (capture_strobe[GR_B0] |->
      age_q >= 4'h1 && age_q <= 4'h5)
      else $error("capture without a recent own pin edge");
   a_d_off: assert property (buffer_b_select |->
      !compare_enabled[GR_D0])
      else $error("register D compare while buffering");
   a_d_nocap: assert property (buffer_b_select &&
      $past(buffer_b_select) |-> !capture_strobe[GR_D0])
      else $error("register D capture while buffering");
endmodule : timer_io_chk

bind timer_io_control_decode timer_io_chk chk (.core_clk, .nrst, .clk_en,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .counter_start_bit, .pwm2_mode,
   .counter_clear, .buffer_b_select, .compare_match, .capture_strobe,
   .compare_enabled, .pin_in, .pin_out, .pin_oe_n);
`default_nettype wire

// ### dv/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pin_partner
   import timer_io_pkg::*;
(
   input  wire logic [NUM_PIN-1:0] pin_out,   // Levels the block drives
   input  wire logic [NUM_PIN-1:0] pin_oe_n,  // Low where the block drives
   input  wire logic [NUM_PIN-1:0] ext_level, // Outside source levels
   output logic      [NUM_PIN-1:0] pin_in     // Level on each pin
);
   always_comb begin
      for (int p = 0; p < NUM_PIN; p++) begin
         pin_in[p] = pin_oe_n[p] ? ext_level[p] : pin_out[p];
      end
   end
endmodule : pin_partner
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import timer_io_pkg::*;
   ;
   localparam logic [7:0] OFS [4] = '{OFS_CH0_HIGH, OFS_CH0_LOW, OFS_CH1,
                                      OFS_CH2};
   logic                core_clk, nrst, clk_en, wb_cyc_i, wb_stb_i, wb_we_i;
   logic                wb_ack_o, buffer_b_select, lvl;
   logic [7:0]          fv;
   logic [WB_ADR_W-1:0] wb_adr_i;
   logic [3:0]          wb_sel_i;
   logic [WB_DAT_W-1:0] wb_dat_i, wb_dat_o, rd;
   logic [NUM_CH-1:0]   counter_start_bit, pwm2_mode, counter_clear;
   logic [NUM_GR-1:0]   compare_match, capture_strobe, compare_enabled;
   logic [NUM_PIN-1:0]  pin_in, pin_out, pin_oe_n, ext_level;
   int                  failures, checked, n;

   timer_io_control_decode dut (.core_clk, .nrst, .clk_en, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .counter_start_bit, .pwm2_mode, .counter_clear,
      .buffer_a_select(1'b0), .buffer_b_select, .compare_match,
      .capture_strobe, .compare_enabled, .pin_in, .pin_out, .pin_oe_n);
   pin_partner far (.pin_out, .pin_oe_n, .ext_level, .pin_in);

   // Timer clock, 100 ns period
   always #50 core_clk = ~core_clk;

   // Counts, verdict and end of run
   task automatic give_verdict;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   // Compare seen against expected
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // One classic bus cycle, read data into rd
   task automatic bus(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, input logic [3:0] sel);
      int k;
      @(posedge core_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {adr, sel, dat};
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      if (wb_ack_o !== 1'b1) begin
         failures++;
         give_verdict();
      end
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : bus

   // Pulse one compare match and let the pin settle
   task automatic hit(input int gr);
      @(posedge core_clk);
      compare_match[gr] <= 1'b1;
      @(posedge core_clk);
      compare_match[gr] <= 1'b0;
      @(posedge core_clk);
   endtask : hit

   // Move an outside level, count own and stray strobes
   task automatic edge_cnt(input int pin, gr, input logic l);
      int other;
      other = 0;
      n = 0;
      @(posedge core_clk);
      ext_level[pin] <= l;
      repeat (8) begin
         @(posedge core_clk);
         n += int'(capture_strobe[gr] === 1'b1);
         other += int'((capture_strobe & ~(8'h1 << gr)) != 8'h0);
      end
      chk("stray capture", 32'(other), 0);
   endtask : edge_cnt

   function automatic logic [3:0] legal();
      return 4'($urandom % 12);
   endfunction : legal

   function automatic logic after_match(input logic [1:0] a, input logic c);
      case (a)
         2'b01:   return 1'b0;
         2'b10:   return 1'b1;
         default: return !c;
      endcase
   endfunction : after_match

   function automatic int cap_exp(input int c, input logic rise);
      case (c)
         8:       return int'(rise);
         9:       return int'(!rise);
         default: return 1;
      endcase
   endfunction : cap_exp

   // Main sequence
   initial begin
      {core_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, buffer_b_select} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i, counter_start_bit, pwm2_mode} = '0;
      {counter_clear, compare_match, ext_level} = '0;
      clk_en = 1'b1;
      failures = 0;
      checked = 0;
      rd = $urandom(10551);
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      // reset values and an unmapped place
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, (i < 4) ? OFS[i] : 8'h20, '0, 4'hf);
         chk("reset value", rd, '0);
      end
      chk("reset enables", 32'(pin_oe_n), 32'h7f);
      $display("reset test done");
      for (int i = 0; i < 24; i++) begin
         n = $urandom % 4;
         fv = {legal(), legal()};
         bus(1'b1, OFS[n], {24'($urandom), fv}, 4'h1);
         bus(1'b1, OFS[n], 32'hffff_ff00 ^ 32'($urandom), 4'he);
         bus(1'b1, 8'h20, 32'($urandom), 4'hf);
         bus(1'b0, OFS[n], '0, 4'hf);
         chk("field readback", rd, 32'(fv));
      end
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, OFS[k], '0, 4'h1);
      end
      $display("register test done");
      // each compare code on pin 3
      for (int c = 1; c < 8; c++) begin
         bus(1'b1, OFS_CH1, 32'(c), 4'h1);
         repeat (2) @(posedge core_clk);
         chk("drive off", 32'(pin_oe_n[3]), 32'(c[1:0] == 2'b00));
         lvl = c[2];
         counter_start_bit[1] <= 1'b1;
         repeat (2) begin
            hit(GR_A1);
            lvl = after_match(c[1:0], lvl);
            if (c[1:0] != 2'b00) begin
               chk("match level", 32'(pin_out[3]), 32'(lvl));
            end
         end
         counter_start_bit[1] <= 1'b0;
         repeat (2) @(posedge core_clk);
         if (c[1:0] != 2'b00) begin
            chk("stopped level", 32'(pin_out[3]), 32'(c[2]));
         end
      end
      bus(1'b1, OFS_CH1, 32'h5, 4'h1);
      {pwm2_mode[1], counter_start_bit[1]} <= 2'b11;
      hit(GR_A1);
      chk("pwm match", 32'(pin_out[3]), 32'h0);
      counter_clear[1] <= 1'b1;
      @(posedge core_clk);
      counter_clear[1] <= 1'b0;
      @(posedge core_clk);
      chk("pwm clear", 32'(pin_out[3]), 32'h1);
      // Clock enable low: a match must not move the pin
      clk_en <= 1'b0;
      hit(GR_A1);
      chk("frozen level", 32'(pin_out[3]), 32'h1);
      clk_en <= 1'b1;
      {pwm2_mode, counter_start_bit} <= '0;
      $display("compare test done");
      for (int c = 8; c < 12; c++) begin
         bus(1'b1, OFS_CH0_HIGH, 32'(c << 4), 4'h1);
         edge_cnt(1, GR_B0, 1'b1);
         chk("rise capture", 32'(n), 32'(cap_exp(c, 1'b1)));
         edge_cnt(1, GR_B0, 1'b0);
         chk("fall capture", 32'(n), 32'(cap_exp(c, 1'b0)));
      end
      // Event flags left behind by captures and matches
      bus(1'b0, OFS_EVENT_FLAGS, '0, 4'hf);
      chk("capture flag", 32'(rd[GR_B0]), 1);
      chk("match flag", 32'(rd[FLAG_MATCH_POS + GR_A1]), 1);
      buffer_b_select <= 1'b1;
      bus(1'b1, OFS_CH0_LOW, 32'h80, 4'h1);
      edge_cnt(2, GR_D0, 1'b1);
      chk("buffered capture", 32'(n), 0);
      bus(1'b1, OFS_CH0_LOW, 32'h10, 4'h1);
      @(posedge core_clk);
      chk("buffered compare", 32'(compare_enabled[GR_D0]), 0);
      bus(1'b1, OFS_CH0_LOW, 32'h90, 4'h1);
      buffer_b_select <= 1'b0;
      edge_cnt(2, GR_D0, 1'b0);
      chk("own pin capture", 32'(n), 1);
      bus(1'b1, OFS_CH0_LOW, 32'h10, 4'h1);
      @(posedge core_clk);
      chk("own compare", 32'(compare_enabled[GR_D0]), 1);
      $display("capture test done");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
